// ==== rtl/svc_att_store.sv ====
// Storage of the six attenuation bytes with registered read-out
`timescale 1ns/100ps
module svc_att_store
  import svc_pkg::*;
#(
  parameter int NUM_CH = SVC_NUM_CH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Write side
  input wire logic wr_en_i,
  input wire logic [3:0] wr_ch_i,
  input wire logic [7:0] wr_data_i,
  // Read side
  output logic [NUM_CH*8-1:0] att_o
);
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          att_o[g*8 +: 8] <= SVC_ATT_RESET;
        end else if (wr_en_i && wr_ch_i == 4'(g)) begin
          att_o[g*8 +: 8] <= wr_data_i;
        end
      end
    end
  endgenerate
endmodule

// ==== rtl/svc_pkg.sv ====
// Package with the constants of the six-channel volume serial slave
package svc_pkg;
  localparam int SVC_NUM_CH = 6;
  localparam logic [6:0] SVC_ADDR_OPEN = 7'h44;
  localparam logic [6:0] SVC_ADDR_SUPPLY = 7'h45;
  localparam logic [3:0] SVC_SUB_LAST = 4'h7;
  localparam logic [3:0] SVC_BIT_LAST = 4'h7;
  localparam logic [3:0] SVC_BIT_ACK = 4'h8;
  localparam int SVC_SUB_AI_POS = 4;
  localparam logic [7:0] SVC_ATT_RESET = 8'hC0;
  localparam logic [6:0] SVC_DB_MUTE = 7'h7F;
  localparam logic [6:0] SVC_DB_64 = 7'h40;
  localparam logic [6:0] SVC_DB_72 = 7'h48;
  typedef enum logic [3:0] {
    SVC_IDLE = 4'b0001,
    SVC_ADDR = 4'b0010,
    SVC_SUB = 4'b0100,
    SVC_DATA = 4'b1000
  } svc_state_t;
endpackage

// ==== rtl/svc_serial_slave.sv ====
// Two-wire serial slave that programs six channel attenuations
`timescale 1ns/100ps
module svc_serial_slave
  import svc_pkg::*;
#(
  parameter int NUM_CH = SVC_NUM_CH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Address select strap, high when tied to supply
  input wire logic addr_sel_i,
  // Channel settings
  output logic [NUM_CH*8-1:0] att_code_o,
  output logic [NUM_CH*7-1:0] att_db_o,
  output logic [NUM_CH-1:0] mute_o
);
  svc_state_t state_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [3:0] sub_r;
  logic auto_inc_r;
  logic ack_r;
  logic wr_en_r;
  logic [3:0] wr_ch_r;
  logic [7:0] wr_data_r;
  logic [NUM_CH*8-1:0] att_w;
  // Count held through the ninth clock so its rise is never taken as data
  localparam logic [3:0] BIT_ACK_DONE = SVC_BIT_ACK + 4'h1;

  wire scl_rise = scl_i && !scl_q_r;
  wire scl_fall = !scl_i && scl_q_r;
  wire start_det = scl_i && scl_q_r && sda_q_r && !sda_i;
  wire stop_det = scl_i && scl_q_r && !sda_q_r && sda_i;
  wire [7:0] byte_w = {shift_r[6:0], sda_i};
  // Last data rise of a byte: the whole byte is visible on byte_w here
  wire byte_end = scl_rise && bit_cnt_r == SVC_BIT_LAST;
  // Falls that open and close the acknowledge slot
  wire ack_open = scl_fall && bit_cnt_r == SVC_BIT_ACK;
  wire ack_close = scl_fall && bit_cnt_r == BIT_ACK_DONE;
  // Write-only part: a read request is treated like a foreign address
  wire addr_match = byte_w[7:1] == (addr_sel_i ? SVC_ADDR_SUPPLY : SVC_ADDR_OPEN)
    && !byte_w[0];

  // Attenuation code to decibels of cut, 7'h7F flags mute
  function automatic logic [6:0] svc_db(input logic [7:0] code);
    logic [6:0] db;
    db = 7'h00;
    unique case (code[7:6])
      2'b00: db = {1'b0, code[5:3], code[2:0]};
      2'b01: db = SVC_DB_64 + {4'h0, code[2:0]};
      2'b10: db = SVC_DB_72 + {4'h0, code[2:0]};
      2'b11: db = SVC_DB_MUTE;
    endcase
    return db;
  endfunction

  // Edge history; inputs are already synchronous
  // Held high in reset like the idle bus, so no false edge follows release
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  // Bit counter and shifter; data sampled on clock rise only
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end else if (start_det || stop_det) begin
      bit_cnt_r <= 4'h0;
    end else if (ack_close) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise && bit_cnt_r == SVC_BIT_ACK) begin
      bit_cnt_r <= BIT_ACK_DONE;
    end else if (scl_rise && bit_cnt_r < SVC_BIT_ACK) begin
      shift_r <= byte_w;
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // Transfer sequencing
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= SVC_IDLE;
      sub_r <= 4'h0;
      auto_inc_r <= 1'b0;
    end else if (start_det) begin
      state_r <= SVC_ADDR; // repeated start also restarts
    end else if (stop_det) begin
      state_r <= SVC_IDLE;
    end else if (byte_end) begin
      unique case (state_r)
        SVC_IDLE: state_r <= SVC_IDLE;
        SVC_ADDR: begin
          if (addr_match) begin
            state_r <= SVC_SUB;
          end else begin
            state_r <= SVC_IDLE;
          end
        end
        SVC_SUB: begin
          sub_r <= byte_w[3:0];
          auto_inc_r <= byte_w[SVC_SUB_AI_POS];
          state_r <= SVC_DATA;
        end
        SVC_DATA: begin
          // Unused slots 6..7 are still walked; codes 8..15 wrap to 0
          if (auto_inc_r) begin
            sub_r <= (sub_r >= SVC_SUB_LAST) ? 4'h0 : sub_r + 4'h1;
          end
        end
      endcase
    end
  end

  // Write strobe to the store; subaddresses past the last channel are dropped
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_en_r <= 1'b0;
      wr_ch_r <= 4'h0;
      wr_data_r <= 8'h00;
    end else begin
      wr_en_r <= byte_end && state_r == SVC_DATA && !start_det && !stop_det
                 && sub_r < 4'(NUM_CH);
      wr_ch_r <= sub_r;
      wr_data_r <= byte_w;
    end
  end

  // Acknowledge: armed at the fall after bit 8, released at the fall after the ninth clock
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_r <= 1'b0;
    end else if (ack_open && state_r != SVC_IDLE) begin
      ack_r <= 1'b1;
    end else if (ack_close) begin
      ack_r <= 1'b0;
    end
  end

  // Pin drive: open drain, enable low while pulling down
  // From the first clock after reset only the enable moves; the drive value stays low so the line is never driven high
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n_o <= !ack_r;
    end
  end

  svc_att_store #(
    .NUM_CH(NUM_CH)
  ) u_store (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(wr_en_r),
    .wr_ch_i(wr_ch_r),
    .wr_data_i(wr_data_r),
    .att_o(att_w)
  );

  // Registered decoded views of each channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_out
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          att_code_o[g*8 +: 8] <= SVC_ATT_RESET;
        end else begin
          att_code_o[g*8 +: 8] <= att_w[g*8 +: 8];
        end
      end
      // Decoded beside the raw code so both views change on the same edge
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          att_db_o[g*7 +: 7] <= SVC_DB_MUTE;
        end else begin
          att_db_o[g*7 +: 7] <= svc_db(att_w[g*8 +: 8]);
        end
      end
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          mute_o[g] <= 1'b1;
        end else begin
          mute_o[g] <= &att_w[g*8+6 +: 2];
        end
      end
    end
  endgenerate
endmodule

// ==== sim/svc_master_model.sv ====
// Two-wire bus master model
`timescale 1ns/100ps
module svc_master_model (
  // Clock
  input wire logic clk_i,
  // Bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic ph(logic c, logic d);
    repeat (4) @(posedge clk_i) begin
      scl_o <= c;
      sda_o <= d;
    end
  endtask
  // Data only moves with the clock low
  task automatic bt(logic b);
    ph(1'b0, sda_o);
    ph(1'b0, b);
    ph(1'b1, b);
  endtask
  task automatic start();
    bt(1'b1);
    ph(1'b1, 1'b0);
  endtask
  task automatic stop();
    bt(1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic wb(logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bt(d[i]);
    bt(1'b1);
    ack = !sda_i;
  endtask
endmodule

// ==== sim/svc_serial_slave_asserts.sv ====
// Port checks for the serial slave
`timescale 1ns/100ps
module svc_serial_slave_asserts #(
  parameter int NUM_CH = 6
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic [NUM_CH*8-1:0] att_code_o,
  input wire logic [NUM_CH*7-1:0] att_db_o,
  input wire logic [NUM_CH-1:0] mute_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence scl_rise;
    !scl_i ##1 scl_i;
  endsequence
  sequence ack_drive;
    !sda_oe_n_o [*4];
  endsequence
  a_drive_low: assert property (!sda_oe_n_o |-> !sda_o)
    else $error("bad drive");
  a_high_stable: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o))
    else $error("moved in high");
  a_ack_hold: assert property (scl_rise ##0 !sda_oe_n_o |-> ack_drive)
    else $error("ack cut");
  a_ack_start: assert property ($fell(sda_oe_n_o) |-> !scl_i &&
    ($past(scl_i, 2) || $past(scl_i, 3) || $past(scl_i, 4))) else $error("ack late");
  a_ack_end: assert property ($rose(sda_oe_n_o) |->
    ($past(scl_i, 2) || $past(scl_i, 3) || $past(scl_i, 4))) else $error("ack end");
  a_code_after_bit: assert property ($changed(att_code_o) |-> $past(scl_i, 2))
    else $error("stray update");
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    a_mute_code: assert property ($stable(att_code_o) [*3] |->
      mute_o[i] == (&att_code_o[8*i+6+:2])) else $error("mute code");
    a_mute_db: assert property ($stable(att_code_o) [*3] |->
      mute_o[i] == (att_db_o[7*i+:7] == 7'h7F)) else $error("mute level");
  end
endmodule
bind svc_serial_slave svc_serial_slave_asserts #(.NUM_CH(NUM_CH)) u_chk (.sys_clk_i,
  .rstn_i, .scl_i, .sda_o, .sda_oe_n_o, .att_code_o, .att_db_o, .mute_o);

// ==== sim/svc_serial_slave_bench.sv ====
// Bench for the serial slave
`timescale 1ns/100ps
`define CHK(a,b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module svc_serial_slave_bench;
  import svc_pkg::*;
  logic sys_clk_i = 0, rstn_i = 0, addr_sel_i = 0, scl, sda_m, sda_o, sda_oe_n_o, ack;
  wire sda_w = sda_m & (sda_oe_n_o | sda_o);
  logic [47:0] code;
  logic [41:0] db;
  logic [5:0] mute;
  logic [7:0] exp_c [6];
  logic [7:0] a;
  int error_cnt = 0, comparisons = 0;
  svc_master_model m (.clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  svc_serial_slave dut (.sys_clk_i, .rstn_i, .scl_i(scl), .sda_i(sda_w), .sda_o,
    .sda_oe_n_o, .addr_sel_i, .att_code_o(code), .att_db_o(db), .mute_o(mute));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  function automatic logic [6:0] db_of(logic [7:0] c);
    case (c[7:6])
      2'b11: return SVC_DB_MUTE;
      2'b01: return SVC_DB_64 + c[2:0];
      2'b10: return SVC_DB_72 + c[2:0];
      default: return 7'(c[5:3] * 8 + c[2:0]);
    endcase
  endfunction
  task automatic results();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic xfer(logic [7:0] s, int n, logic hit, logic [7:0] ad);
    logic [7:0] d;
    logic [3:0] k;
    k = s[3:0];
    m.start();
    m.wb(ad, ack);
    `CHK(ack, hit)
    m.wb(s, ack);
    // Bytes keep coming whatever the answer
    for (int j = 0; j < n; j++) begin
      `CHK(ack, hit)
      d = 8'($urandom);
      m.wb(d, ack);
      if (hit && k < 6) exp_c[k] = d;
      if (s[4]) k = (k >= 7) ? 4'h0 : k + 4'h1;
    end
    `CHK(ack, hit)
    m.stop();
    repeat (6) @(posedge sys_clk_i);
    for (int i = 0; i < 6; i++) begin
      `CHK(code[8*i+:8], exp_c[i])
      `CHK(db[7*i+:7], db_of(exp_c[i]))
      `CHK(mute[i], &exp_c[i][7:6])
    end
  endtask
  initial begin
    void'($urandom(32'h1BA93576));
    for (int i = 0; i < 6; i++) exp_c[i] = SVC_ATT_RESET;
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    for (int s = 0; s < 2; s++) begin
      addr_sel_i <= s[0];
      a = s[0] ? 8'h8A : 8'h88;
      xfer(8'($urandom_range(5)), 3, 1'b1, a);
      xfer(8'h10, 4, 1'b0, a ^ 8'h02);
      xfer(8'h10, 2, 1'b0, a | 8'h01);
      xfer(8'h12, 8, 1'b1, a);
      xfer(8'h06, 2, 1'b1, a);
      xfer(8'h1D, 3, 1'b1, a);
      repeat (5) xfer(8'($urandom) & 8'hF7, $urandom_range(1, 9), 1'b1, a);
    end
    results();
  end
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    error_cnt++;
    results();
  end
endmodule
